//--- shared/acp_pkg.sv
// acp_pkg: constants and types of the ascii command parser
// assumes a 10 MHz single clock and a byte-wide receive stream
package acp_pkg;
  // ==========================================
  // timing
  localparam int CLK_MHZ = 10;
  localparam int GAP_TIME_US = 10000; // longest quiet time inside a frame
  localparam int GAP_CYC = GAP_TIME_US * CLK_MHZ;
  localparam int MATCH_DEPTH = 64;
  // ==========================================
  // characters
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_END = 8'h04;
  // ==========================================
  // command framing
  localparam logic [2:0] POS_PAIR = 3'd1; // last char of a two-char header
  localparam logic [2:0] POS_QUAD = 3'd3; // last char of a four-char header
  localparam logic [2:0] POS_FIVE = 3'd4; // last char of the match header
  localparam logic [2:0] TRIG_MAX = 3'd4; // longest trigger text
  localparam logic [6:0] SEL_MAX = 7'd15;
  localparam logic [6:0] SAVE_MIN = 7'd1;
  localparam logic [6:0] SAVE_MAX = 7'd5;
  localparam logic [3:0] RPL_LAST = 4'd9; // end byte of the ten-byte reply
  localparam logic [3:0] DEC_TEN = 4'd10;
  // ==========================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_TRIG = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_MLEN = 8'h0c;
  localparam logic [7:0] REG_MIDX = 8'h10;
  localparam logic [7:0] REG_MDATA = 8'h14;
  localparam logic [31:0] TRIG_RST = 32'h0000_0054;
  localparam logic [31:0] CFG_RST = 32'h0000_0039;
  localparam int CFG_LEN_LSB = 0;
  localparam int CFG_SAME = 3;
  localparam int CFG_MEN = 4;
  localparam int CFG_OCR = 5;
  localparam int STAT_LOCK = 0;
  localparam int STAT_PROC = 1;
  localparam int STAT_MVAL = 2;
  localparam int STAT_PROG_LSB = 4;
  localparam int STAT_DIAG_LSB = 8;
  // ==========================================
  // types
  typedef enum logic [1:0] {ST_HDR, ST_NUM, ST_LEN, ST_DATA} acp_state_t;
endpackage : acp_pkg

//--- shared/acp_rpl_if.sv
// acp_rpl_if: status reply request from parser to reply sender
// assumes both ends run on the parser clock
`timescale 1ns/10ps
interface acp_rpl_if;
  logic start;
  logic [7:0] status;
  logic [3:0] prog;
  logic [3:0] err;
  logic busy;
  modport req (output start, output status, output prog, output err, input busy);
  modport snd (input start, input status, input prog, input err, output busy);
endinterface : acp_rpl_if

//--- rtl/acp_reply_tx.sv
// acp_reply_tx: sends the ten-byte status reply frame
// assumes the transmit sink stalls with tx_ready and a start is held off while busy
`timescale 1ns/10ps
module acp_reply_tx
  import acp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  acp_rpl_if.snd rq,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  logic [7:0] st;
  logic [3:0] pg;
  logic [3:0] er;
  logic [3:0] idx;

  // two ascii decimal digits for 0..15
  function automatic logic [7:0] dig(input logic [3:0] v, input logic tens);
    logic [3:0] o;
    o = (v >= DEC_TEN) ? v - DEC_TEN : v;
    if (tens) dig = (v >= DEC_TEN) ? CH_0 + 8'h01 : CH_0;
    else dig = CH_0 + {4'h0, o};
  endfunction : dig

  function automatic logic [7:0] byte_at(input logic [3:0] i);
    case (i)
      4'd0: byte_at = CH_R;
      4'd1: byte_at = CH_G;
      4'd2: byte_at = CH_S;
      4'd3: byte_at = CH_T;
      4'd4: byte_at = st;
      4'd5: byte_at = dig(pg, 1'b1);
      4'd6: byte_at = dig(pg, 1'b0);
      4'd7: byte_at = dig(er, 1'b1);
      default: byte_at = dig(er, 1'b0);
    endcase
  endfunction : byte_at

  assign rq.busy = tx_valid;

  // capture fields at start so the frame is self-consistent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= 8'h00;
      pg <= 4'h0;
      er <= 4'h0;
    end else if (rq.start && !tx_valid) begin
      st <= rq.status;
      pg <= rq.prog;
      er <= rq.err;
    end
  end

  // byte sequencer, stalls on tx_ready
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      idx <= 4'h0;
    end else if (!tx_valid) begin
      if (rq.start) begin
        tx_valid <= 1'b1;
        tx_data <= CH_R; // header first [RQ10]
        idx <= 4'h1;
      end
    end else if (tx_ready) begin
      if (idx > RPL_LAST) begin
        tx_valid <= 1'b0;
      end else begin
        tx_data <= (idx == RPL_LAST) ? CH_END : byte_at(idx); // digits 00..15 [RQ11]
        idx <= idx + 4'h1;
      end
    end
  end

  a_reply_head: assert property (@(posedge clk) disable iff (!rst_b) // [RQ10]
    rq.start && !tx_valid |=> tx_valid && tx_data == CH_R)
    else $error("reply does not open with header");
endmodule : acp_reply_tx

//--- rtl/acp_cmd_parser.sv
// acp_cmd_parser: ascii command interpreter of the code reader
// assumes received bytes arrive one per rx_valid cycle, synchronous to clk
// Operation
// (RQ1) a string equal to the trigger text starts acquisition
// (RQ2) a new match string applies at once, not aligned to acquisition
// (RQ3) match frame: five-char header, big-endian 16-bit length, then text
// (RQ4) overwrite accepted only in processing mode with matching enabled
// (RQ5) overwritten match dropped on leaving processing or program change
// (RQ6) match reception aborted if the gap between characters is too long
// (RQ7) a refused overwrite records a diagnostic entry
// (RQ8) partner sends each special character as one raw byte
// (RQ9) set command raises lockout bit, clear command lowers it
// (RQ10) status query answered with header, status, program, error, end byte
// (RQ11) program and error are two decimal digits 00..15, 00 is no error
// (RQ12) program select switches to that program if it exists, no reply
// (RQ13) a command directly followed by a query in one string works
// (RQ14) select and save raise lockout automatically if clear, then drop it
// (RQ15) internal-trigger save needs same connection for trigger and control
// (RQ16) internal save starts saving, triggers acquisition, no reply
// (RQ17) a good save replaces the program of the same number
// (RQ18) save number valid only from 01 to 5
// (RQ19) match accepted only with text-filter or char-type filter set
// (RQ20) non-numeric or out-of-range numbers are ignored without effect
// (RQ21) commands discarded until restart completes
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module acp_cmd_parser
  import acp_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int DEPTH = MATCH_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic restart_done,
  input wire logic [15:0] prog_exists,
  input wire logic [7:0] status_byte,
  input wire logic [3:0] err_num,
  input wire logic leave_proc,
  input wire logic op_done,
  input wire logic op_ok,
  output logic acq_trigger,
  output logic sel_start,
  output logic save_start,
  output logic [3:0] op_prog,
  output logic local_control_lockout_bit,
  output logic processing,
  output logic [3:0] cur_prog,
  output logic match_valid,
  output logic diag_event
);
  // ==========================================
  // elaboration checks
  if (DEPTH < 1 || DEPTH > 65535) begin : g_bad_depth
    $error("DEPTH out of range");
  end
  if (GAP_CYCLES < 2) begin : g_bad_gap
    $error("GAP_CYCLES too small");
  end

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int GW = $clog2(GAP_CYCLES + 1);

  // ==========================================
  // declarations
  acp_state_t state;
  logic [2:0] cnt;
  logic [7:0] hdr [0:3];
  logic [7:0] num_hi;
  logic is_save;
  logic [15:0] len_rx;
  logic [15:0] dcnt;
  logic [GW-1:0] gap_cnt;
  logic [31:0] trig_reg;
  logic [31:0] cfg_reg;
  logic [7:0] mem [0:DEPTH-1];
  logic [15:0] match_len;
  logic [IW-1:0] midx;
  logic m_ok;
  logic op_busy;
  logic auto_lock;
  logic [7:0] diag_cnt;
  logic rx_take, trig_hit, gap_hit, parsing;
  logic cmd_set, cmd_clr, cmd_gst, num_done, sel_ok, save_ok;
  logic len_done, accept, data_last;
  logic [15:0] next_len;
  logic [15:0] w2;
  logic [31:0] w4;
  logic [2:0] trig_len;
  logic digits_ok;
  logic [6:0] num_val;
  acp_rpl_if rpl ();

  // ==========================================
  // decode of the incoming byte
  assign rx_take = rx_valid && restart_done; // muted until restart completes [RQ21]
  assign trig_len = cfg_reg[CFG_LEN_LSB +: 3];
  assign w2 = {hdr[0], rx_data};
  assign w4 = {hdr[0], hdr[1], hdr[2], rx_data};
  assign parsing = (state != ST_HDR) || (cnt != 3'd0);
  assign gap_hit = parsing && (gap_cnt == GW'(GAP_CYCLES - 1));
  // commands may follow each other in one string, header restarts each time [RQ13]
  assign cmd_set = rx_take && state == ST_HDR && cnt == POS_QUAD && w4 == {CH_M, CH_D, CH_I, CH_H};
  assign cmd_clr = rx_take && state == ST_HDR && cnt == POS_QUAD && w4 == {CH_M, CH_D, CH_I, CH_L};
  assign cmd_gst = rx_take && state == ST_HDR && cnt == POS_QUAD && w4 == {CH_M, CH_G, CH_S, CH_T};

  // trigger text compare, up to four characters [RQ1]
  always_comb begin
    trig_hit = rx_take && (state == ST_HDR) && (trig_len != 3'd0) && (trig_len <= TRIG_MAX)
               && (trig_len == cnt + 3'd1);
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < cnt && hdr[i] != trig_reg[8*i +: 8]) trig_hit = 1'b0;
      if (3'(i) == cnt && rx_data != trig_reg[8*i +: 8]) trig_hit = 1'b0;
    end
  end

  // program number: two ascii digits, anything else is ignored [RQ20]
  assign digits_ok = num_hi >= CH_0 && num_hi <= CH_9 && rx_data >= CH_0 && rx_data <= CH_9;
  assign num_val = 7'((num_hi - CH_0) * 8'd10) + 7'(rx_data - CH_0);
  assign num_done = rx_take && state == ST_NUM && cnt == 3'd1;
  assign sel_ok = num_done && !is_save && digits_ok && num_val <= SEL_MAX
                  && prog_exists[num_val[3:0]] && !op_busy; // existing program only [RQ12]
  assign save_ok = num_done && is_save && digits_ok && num_val >= SAVE_MIN
                   && num_val <= SAVE_MAX // [RQ18]
                   && cfg_reg[CFG_SAME] && !op_busy; // [RQ15]

  // match frame: length high byte then low byte [RQ3]
  assign next_len = {len_rx[15:8], rx_data};
  assign len_done = rx_take && state == ST_LEN && cnt == 3'd1;
  assign accept = processing && cfg_reg[CFG_MEN] // [RQ4]
                  && cfg_reg[CFG_OCR] // [RQ19]
                  && next_len <= 16'(DEPTH);
  assign data_last = rx_take && state == ST_DATA && dcnt == len_rx - 16'h0001;

  // ==========================================
  // parse state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_HDR;
      cnt <= 3'd0;
      is_save <= 1'b0;
      num_hi <= 8'h00;
      len_rx <= 16'h0000;
      dcnt <= 16'h0000;
      for (int i = 0; i < 4; i++) hdr[i] <= 8'h00;
    end else if (gap_hit) begin
      state <= ST_HDR; // burst broke apart, drop the frame [RQ6]
      cnt <= 3'd0;
    end else if (rx_take) begin
      case (state)
        ST_HDR: begin
          if (cnt < POS_FIVE) hdr[cnt[1:0]] <= rx_data;
          if (trig_hit) begin
            cnt <= 3'd0;
          end else if (cnt == 3'd0 && rx_data != CH_M && rx_data != trig_reg[7:0]) begin
            cnt <= 3'd0; // neither command nor trigger start, resync
          end else if (cnt == POS_PAIR && (w2 == {CH_M, CH_R} || w2 == {CH_M, CH_I})) begin
            state <= ST_NUM;
            cnt <= 3'd0;
            is_save <= (rx_data == CH_I);
          end else if (cnt == POS_QUAD && w4 != {CH_M, CH_A, CH_T, CH_C}) begin
            cnt <= 3'd0;
          end else if (cnt == POS_FIVE) begin
            cnt <= 3'd0;
            if (rx_data == CH_H) state <= ST_LEN;
          end else begin
            cnt <= cnt + 3'd1;
          end
        end
        ST_NUM: begin
          if (cnt == 3'd0) begin
            num_hi <= rx_data;
            cnt <= 3'd1;
          end else begin
            state <= ST_HDR;
            cnt <= 3'd0;
          end
        end
        ST_LEN: begin
          if (cnt == 3'd0) begin
            len_rx[15:8] <= rx_data;
            cnt <= 3'd1;
          end else begin
            len_rx <= next_len;
            dcnt <= 16'h0000;
            cnt <= 3'd0;
            state <= (next_len == 16'h0000) ? ST_HDR : ST_DATA;
          end
        end
        ST_DATA: begin
          dcnt <= dcnt + 16'h0001;
          if (data_last) state <= ST_HDR;
        end
        default: begin
          state <= ST_HDR;
          cnt <= 3'd0;
        end
      endcase
    end
  end

  // inter-character gap timer, reloads on every byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) gap_cnt <= '0;
    else if (rx_take || !parsing || gap_hit) gap_cnt <= '0;
    else gap_cnt <= gap_cnt + GW'(1);
  end

  // ==========================================
  // match string store: bytes land directly, so the string acts at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m_ok <= 1'b0;
      match_valid <= 1'b0;
      match_len <= 16'h0000;
    end else begin
      if (len_done) begin
        m_ok <= accept && next_len != 16'h0000;
        if (accept) begin
          match_valid <= (next_len == 16'h0000);
          match_len <= next_len;
        end
      end else if (data_last && m_ok) begin
        match_valid <= 1'b1; // no wait for any acquisition [RQ2]
        m_ok <= 1'b0;
      end else if (gap_hit) begin
        m_ok <= 1'b0;
      end
      // non-persistent copy dies with processing mode or program change [RQ5]
      if (leave_proc || sel_ok || save_ok || (op_done && op_ok)) begin
        match_valid <= 1'b0;
        m_ok <= 1'b0;
      end
    end
  end

  // raw bytes stored unchanged, specials arrive as one code [RQ8]
  always_ff @(posedge clk) begin
    if (rx_take && state == ST_DATA && m_ok && dcnt < 16'(DEPTH)) mem[dcnt[IW-1:0]] <= rx_data;
  end

  // diagnostic entry when an overwrite cannot be done
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      diag_event <= 1'b0;
      diag_cnt <= 8'h00;
    end else begin
      diag_event <= (len_done && !accept) || (gap_hit && state == ST_DATA && m_ok); // [RQ7]
      if (diag_event && diag_cnt != 8'hff) diag_cnt <= diag_cnt + 8'h01;
    end
  end

  // ==========================================
  // program select and internal-trigger save
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acq_trigger <= 1'b0;
      sel_start <= 1'b0;
      save_start <= 1'b0;
      op_prog <= 4'h0;
      op_busy <= 1'b0;
    end else begin
      acq_trigger <= trig_hit || save_ok; // save makes its own trigger [RQ1] [RQ16]
      sel_start <= sel_ok; // [RQ12]
      save_start <= save_ok; // core overwrites any program of that number [RQ17]
      if (sel_ok || save_ok) begin
        op_prog <= num_val[3:0];
        op_busy <= 1'b1;
      end else if (op_done) begin
        op_busy <= 1'b0;
      end
    end
  end

  // mode and program held for status replies
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      processing <= 1'b0;
      cur_prog <= 4'h0;
    end else if (op_done && op_ok && op_busy) begin
      processing <= 1'b1; // [RQ16]
      cur_prog <= op_prog;
    end else if (leave_proc || sel_ok || save_ok) begin
      processing <= 1'b0;
    end
  end

  // lockout bit; automatic raise is undone when the operation ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      local_control_lockout_bit <= 1'b0;
      auto_lock <= 1'b0;
    end else if (cmd_set) begin
      local_control_lockout_bit <= 1'b1; // [RQ9]
      auto_lock <= 1'b0;
    end else if (cmd_clr) begin
      local_control_lockout_bit <= 1'b0; // [RQ9]
      auto_lock <= 1'b0;
    end else if (sel_ok || save_ok) begin
      local_control_lockout_bit <= 1'b1; // [RQ14]
      auto_lock <= !local_control_lockout_bit;
    end else if (op_done && auto_lock) begin
      local_control_lockout_bit <= 1'b0; // [RQ14]
      auto_lock <= 1'b0;
    end
  end

  // ==========================================
  // status reply; a query while a reply is going out is dropped
  assign rpl.start = cmd_gst && !rpl.busy; // [RQ10]
  assign rpl.status = status_byte;
  assign rpl.prog = cur_prog; // [RQ11]
  assign rpl.err = err_num; // [RQ11]

  acp_reply_tx u_reply (
    .clk(clk),
    .rst_b(rst_b),
    .rq(rpl),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  // ==========================================
  // register port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_reg <= TRIG_RST;
      cfg_reg <= CFG_RST;
      midx <= '0;
    end else if (reg_wr) begin
      if (reg_addr == REG_TRIG) trig_reg <= reg_wdata;
      if (reg_addr == REG_CFG) cfg_reg <= {26'h0, reg_wdata[5:0]};
      if (reg_addr == REG_MIDX) midx <= reg_wdata[IW-1:0];
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_TRIG: reg_rdata <= trig_reg;
        REG_CFG: reg_rdata <= cfg_reg;
        REG_STAT: begin
          reg_rdata <= 32'h0;
          reg_rdata[STAT_LOCK] <= local_control_lockout_bit;
          reg_rdata[STAT_PROC] <= processing;
          reg_rdata[STAT_MVAL] <= match_valid;
          reg_rdata[STAT_PROG_LSB +: 4] <= cur_prog;
          reg_rdata[STAT_DIAG_LSB +: 8] <= diag_cnt;
        end
        REG_MLEN: reg_rdata <= {16'h0, match_len};
        REG_MIDX: reg_rdata <= 32'(midx);
        REG_MDATA: reg_rdata <= {24'h0, mem[midx]};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ==========================================
  // checks
  a_trig_start: assert property (@(posedge clk) disable iff (!rst_b) // [RQ1]
    trig_hit |=> acq_trigger)
    else $error("trigger text did not start acquisition");
  a_lock_set: assert property (@(posedge clk) disable iff (!rst_b) // [RQ9]
    cmd_set |=> local_control_lockout_bit)
    else $error("set command left lockout low");
  a_lock_clear: assert property (@(posedge clk) disable iff (!rst_b) // [RQ9]
    cmd_clr |=> !local_control_lockout_bit)
    else $error("clear command left lockout high");
  a_restart_mute: assert property (@(posedge clk) disable iff (!rst_b) // [RQ21]
    !restart_done && !$past(restart_done) |-> !sel_start && !save_start && !tx_valid)
    else $error("command acted before restart");
  a_save_range: assert property (@(posedge clk) disable iff (!rst_b) // [RQ18]
    save_start |-> op_prog >= 4'd1 && op_prog <= 4'd5 && acq_trigger)
    else $error("save outside range or without trigger");
  a_match_drop: assert property (@(posedge clk) disable iff (!rst_b) // [RQ5]
    leave_proc |=> !match_valid && !processing)
    else $error("match kept after leaving processing");
  a_gap_abort: assert property (@(posedge clk) disable iff (!rst_b) // [RQ6]
    gap_hit |=> state == ST_HDR && cnt == 3'd0)
    else $error("gap did not abort frame");
  a_reject_diag: assert property (@(posedge clk) disable iff (!rst_b) // [RQ7]
    len_done && !accept && !leave_proc && !op_done |=> diag_event && $stable(match_valid))
    else $error("refused overwrite not recorded or applied");
  a_auto_lock: assert property (@(posedge clk) disable iff (!rst_b) // [RQ14]
    sel_start |-> local_control_lockout_bit)
    else $error("lockout not held during select");
endmodule : acp_cmd_parser

//--- test/acp_host_model.sv
// acp_host_model: automation partner side, takes in the status reply
// assumes one clock shared with the parser and the tx handshake
`timescale 1ns/10ps
module acp_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  // ==========================================
  // reply sink
  logic [7:0] got_q[$];
  // random back-pressure, so every reply byte must stand until taken
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= stall ? 1'($urandom_range(1, 0)) : 1'b1;
      if (tx_valid && tx_ready) begin
        got_q.push_back(tx_data);
      end
    end
  end
endmodule : acp_host_model

//--- test/acp_cmd_parser_tb_top.sv
// acp_cmd_parser_tb_top: self-checking bench of the command parser
// assumes the partner model in acp_host_model and a 10 MHz clock
`timescale 1ns/10ps
module acp_cmd_parser_tb_top
  import acp_pkg::*;
;
  // ==========================================
  // stimulus and observation
  logic clk = 0, rst_b = 0, rx_valid = 0, reg_wr = 0, reg_rd = 0, restart_done = 0;
  logic leave_proc = 0, op_done = 0, op_ok = 0, stall = 0, tx_ready, tx_valid;
  logic [7:0] rx_data = 0, reg_addr = 0, status_byte = 0, tx_data;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [15:0] prog_exists = 16'h0020;
  logic [3:0] err_num = 0, op_prog, cur_prog;
  logic acq, sel, save, lock, proc, mval, diag;
  int err_total = 0, cmp_count = 0, n_acq = 0, n_sel = 0, n_save = 0, n_diag = 0;
  always #50 clk = ~clk;
  // pulse tallies, so a missing or doubled pulse shows as a count
  always @(posedge clk) begin
    n_acq += int'(acq === 1'b1);
    n_sel += int'(sel === 1'b1);
    n_save += int'(save === 1'b1);
    n_diag += int'(diag === 1'b1);
  end
  // short gap count keeps the abort case quick
  acp_cmd_parser #(.GAP_CYCLES(20)) u_acp_cmd_parser (.clk(clk), .rst_b(rst_b),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .restart_done(restart_done),
    .prog_exists(prog_exists), .status_byte(status_byte), .err_num(err_num),
    .leave_proc(leave_proc), .op_done(op_done), .op_ok(op_ok), .acq_trigger(acq),
    .sel_start(sel), .save_start(save), .op_prog(op_prog),
    .local_control_lockout_bit(lock), .processing(proc), .cur_prog(cur_prog),
    .match_valid(mval), .diag_event(diag));
  acp_host_model u_acp_host_model (.clk(clk), .rst_b(rst_b), .stall(stall),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // ==========================================
  // tasks
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // one contiguous burst, a byte every cycle, then room for the answer
  task automatic send_q(input logic [7:0] q[$]);
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data <= q[i];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : send_q
  task automatic send(input string s);
    logic [7:0] q[$];
    foreach (s[i]) q.push_back(s[i]);
    send_q(q);
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask : rd
  task automatic pulse_in(input int k);
    if (k == 0) leave_proc <= 1'b1;
    else {op_done, op_ok} <= 2'b11;
    @(posedge clk);
    {leave_proc, op_done, op_ok} <= 3'b000;
    repeat (2) @(posedge clk);
  endtask : pulse_in
  function automatic logic [7:0] dig(input logic [3:0] v);
    return CH_0 + 8'(v);
  endfunction : dig
  task automatic chk_reply(input logic [7:0] st, input logic [3:0] pg, input logic [3:0] er);
    logic [7:0] e[$];
    int n;
    e = {CH_R, CH_G, CH_S, CH_T, st, dig(pg / 10), dig(pg % 10), dig(er / 10), dig(er % 10),
      CH_END};
    n = 0;
    while (u_acp_host_model.got_q.size() < 10 && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    cmp("reply length", 10, u_acp_host_model.got_q.size());
    if (n == 300) give_verdict();
    foreach (e[i]) cmp("reply byte", e[i], u_acp_host_model.got_q[i]);
    u_acp_host_model.got_q.delete();
  endtask : chk_reply
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [7:0] st;
    logic [3:0] er;
    logic [7:0] mf[$];
    void'($urandom(32'h1d4c));
    mf = {CH_M, CH_A, CH_T, CH_C, CH_H, 8'h00, 8'h03, CH_A, 8'h0d, CH_C};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(REG_TRIG, d);
    cmp("trig reset", TRIG_RST, d);
    rd(REG_CFG, d);
    cmp("cfg reset", CFG_RST, d);
    rd(8'hfc, d);
    cmp("unmapped read", 0, d);
    send("TMDIH");
    cmp("acq restarting", 0, n_acq);
    cmp("lock restarting", 0, lock);
    restart_done <= 1'b1;
    send("T");
    cmp("acq", 1, n_acq);
    send("MDIH");
    cmp("lock set", 1, lock);
    send("MDIL");
    cmp("lock clear", 0, lock);
    stall <= 1'b1;
    repeat (3) begin
      st = 8'($urandom);
      er = 4'($urandom_range(15, 0));
      status_byte <= st;
      err_num <= er;
      send("MGST");
      chk_reply(st, 4'd0, er);
    end
    // bad digits, out of range and a missing program all leave no trace
    send("MR16MRx5MR03MI06MI00MI0x");
    cmp("bad sel", 0, n_sel);
    cmp("bad save", 0, n_save);
    cmp("bad lock", 0, lock);
    send("MR05MGST");
    cmp("sel", 1, n_sel);
    cmp("sel prog", 5, op_prog);
    cmp("sel auto lock", 1, lock);
    chk_reply(st, 4'd0, er);
    pulse_in(1);
    cmp("sel cur", 5, cur_prog);
    cmp("sel proc", 1, proc);
    cmp("sel lock drop", 0, lock);
    wr(REG_CFG, 32'h31);
    rd(REG_CFG, d);
    cmp("cfg write", 32'h31, d);
    send("MI03");
    cmp("save other link", 0, n_save);
    wr(REG_CFG, CFG_RST);
    send("MI05");
    cmp("save", 1, n_save);
    cmp("save prog", 5, op_prog);
    cmp("save auto lock", 1, lock);
    pulse_in(1);
    cmp("save cur", 5, cur_prog);
    cmp("save proc", 1, proc);
    cmp("save lock drop", 0, lock);
    send_q(mf);
    cmp("match valid", 1, mval);
    rd(REG_MLEN, d);
    cmp("match len", 3, d);
    send_q(mf[0:7]);
    repeat (30) @(posedge clk);
    cmp("gap abort diag", 1, n_diag);
    wr(REG_CFG, 32'h19);
    send_q(mf);
    cmp("no filter diag", 2, n_diag);
    wr(REG_CFG, CFG_RST);
    send_q(mf);
    cmp("match again", 1, mval);
    pulse_in(0);
    cmp("match dropped", 0, mval);
    cmp("proc left", 0, proc);
    send_q(mf);
    cmp("refused diag", 3, n_diag);
    cmp("refused valid", 0, mval);
    give_verdict();
  end
endmodule : acp_cmd_parser_tb_top
